// File: rtl/snce_pkg.sv
package snce_pkg;

    localparam int PC_W = 21;
    localparam int DADDR_W = 12;
    localparam int INSTR_W = 16;
    localparam int STACK_DEPTH = 31;
    localparam int FLAG_W = 5;

    localparam logic [INSTR_W-1:0] OPC_NEG_MASK = 16'hFE00;
    localparam logic [INSTR_W-1:0] OPC_NEG_VAL = 16'h6C00;
    localparam logic [INSTR_W-1:0] OPC_POP = 16'h0006;
    localparam logic [INSTR_W-1:0] OPC_PUSH = 16'h0005;
    localparam logic [INSTR_W-1:0] OPC_CALL_MASK = 16'hF800;
    localparam logic [INSTR_W-1:0] OPC_CALL_VAL = 16'hD800;
    localparam logic [INSTR_W-1:0] OPC_SRST = 16'h00FF;
    localparam logic [INSTR_W-1:0] OPC_IDLE_ZERO = 16'h0000;
    localparam logic [INSTR_W-1:0] OPC_IDLE_MASK = 16'hF000;
    localparam logic [INSTR_W-1:0] OPC_IDLE_VAL = 16'hF000;

    localparam int ACCESS_BIT = 8;
    localparam int CALL_OFS_W = 11;

    localparam logic [7:0] IDX_LIMIT = 8'h5F;
    localparam logic [7:0] ACCESS_SPLIT_STD = 8'h80;
    localparam logic [7:0] ACCESS_SPLIT_EXT = 8'h60;
    localparam logic [3:0] SFR_BANK = 4'hF;
    localparam logic [3:0] LOW_BANK = 4'h0;
    localparam logic [7:0] BSR_KEEP_MASK = 8'h0F;

    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
    localparam logic [7:0] BSR_RESET = 8'h00;
    localparam logic [FLAG_W-1:0] FLAGS_RESET = 5'h00;

    localparam int FLAG_C = 0;
    localparam int FLAG_DC = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_N = 4;

    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} snce_phase_type;

    typedef enum logic [2:0] {
        OP_NONE, OP_IDLE, OP_NEG, OP_POP, OP_PUSH, OP_CALL, OP_SRST, OP_OTHER
    } snce_op_type;

    function automatic snce_op_type snce_decode(input logic [INSTR_W-1:0] w);
        snce_op_type op;
        op = OP_OTHER;
        if (w == OPC_IDLE_ZERO || (w & OPC_IDLE_MASK) == OPC_IDLE_VAL) begin
            op = OP_IDLE;
        end else if ((w & OPC_NEG_MASK) == OPC_NEG_VAL) begin
            op = OP_NEG;
        end else if (w == OPC_POP) begin
            op = OP_POP;
        end else if (w == OPC_PUSH) begin
            op = OP_PUSH;
        end else if ((w & OPC_CALL_MASK) == OPC_CALL_VAL) begin
            op = OP_CALL;
        end else if (w == OPC_SRST) begin
            op = OP_SRST;
        end
        return op;
    endfunction

endpackage

// File: rtl/snce_ret_stack.sv
`timescale 1ns/1ps
`default_nettype none

module snce_ret_stack #(
    parameter int DEPTH = 31,
    parameter int WIDTH = 21
) (
    input wire logic sys_clk_i,
    input wire logic ce_i,
    input wire logic clear_i,
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic [WIDTH-1:0] push_data_i,
    output logic [WIDTH-1:0] stack_top_o,
    output logic [$clog2(DEPTH+1)-1:0] level_o
);

    localparam int LW = $clog2(DEPTH + 1);
    localparam logic [LW-1:0] FULL = LW'(DEPTH);
    localparam logic [LW-1:0] ONE = LW'(1);
    localparam logic [LW-1:0] TWO = LW'(2);

    initial begin
        if (DEPTH < 2 || WIDTH < 1) begin
            $error("snce_ret_stack needs DEPTH of at least 2");
        end
    end

    // Entries below the top; the top itself lives in its own flop so that it can be driven out directly.
    logic [WIDTH-1:0] below_mem [DEPTH-1];
    logic [WIDTH-1:0] top_reg;
    logic [LW-1:0] level_reg;

    always_ff @(posedge sys_clk_i) begin
        if (clear_i) begin
            top_reg <= '0;
            level_reg <= '0;
        end else if (ce_i) begin
            if (push_i) begin
                if (level_reg != '0 && level_reg < FULL) begin
                    below_mem[level_reg - ONE] <= top_reg;
                end
                top_reg <= push_data_i;
                if (level_reg < FULL) begin
                    level_reg <= level_reg + ONE;
                end
            end else if (pop_i) begin
                if (level_reg > ONE) begin
                    top_reg <= below_mem[level_reg - TWO];
                end else begin
                    top_reg <= '0;
                end
                if (level_reg != '0) begin
                    level_reg <= level_reg - ONE;
                end
            end
        end
    end

    assign stack_top_o = top_reg;
    assign level_o = level_reg;

endmodule

`default_nettype wire

// File: rtl/snce_core.sv
// How it works
// - Negate addressed byte, update five flags.
// - Access bit zero selects fixed access bank.
// - Access bit one uses bank select register.
// - Extended mode, operand up to 5Fh indexes.
// - Pop discards stack top in third quarter.
// - After pop, previous entry becomes stack top.
// - Push writes PC plus two, second quarter.
// - Push moves old top one level down, unless the stack is full.
// - Relative call decodes signed 11-bit word offset.
// - Call pushes return address before PC update.
// - Target is PC plus two plus 2n; two cycles.
// - Software reset clears master-clear state from Q2.
// - Bank select upper four bits stay zero.
`timescale 1ns/1ps
`default_nettype none

module snce_core
    import snce_pkg::*;
#(
    parameter int STACK_DEPTH_P = snce_pkg::STACK_DEPTH
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic [snce_pkg::INSTR_W-1:0] instr_i,
    input wire logic instr_valid_i,
    input wire logic ext_set_en_i,
    input wire logic bsr_load_i,
    input wire logic [7:0] bsr_wdata_i,
    input wire logic [snce_pkg::DADDR_W-1:0] index_base_i,
    input wire logic master_clear_pin_n_i,
    input wire logic [7:0] dmem_rdata_i,
    output logic instr_taken_o,
    output logic foreign_op_o,
    output logic call_flush_o,
    output logic [snce_pkg::DADDR_W-1:0] dmem_addr_o,
    output logic dmem_rd_o,
    output logic dmem_wr_o,
    output logic [7:0] dmem_wdata_o,
    output logic [snce_pkg::FLAG_W-1:0] status_flags_o,
    output logic [7:0] bank_select_o,
    output logic [snce_pkg::PC_W-1:0] pc_o,
    output logic [snce_pkg::PC_W-1:0] stack_top_o,
    output logic [$clog2(STACK_DEPTH_P+1)-1:0] stack_level_o,
    output logic soft_reset_o
);

    import snce_pkg::*;

    initial begin
        if (STACK_DEPTH_P < 2) begin
            $error("snce_core needs a return stack of at least two levels");
        end
    end

    function automatic logic [DADDR_W-1:0] data_addr(
        input logic acc, input logic [7:0] f, input logic [7:0] bank_select_reg,
        input logic ext, input logic [DADDR_W-1:0] base
    );
        logic [DADDR_W-1:0] a;
        a = '0;
        if (acc) begin
            a = {bank_select_reg[3:0], f};
        end else if (ext && f <= IDX_LIMIT) begin
            a = DADDR_W'(base + {4'h0, f});
        end else if (f < (ext ? ACCESS_SPLIT_EXT : ACCESS_SPLIT_STD)) begin
            a = {LOW_BANK, f};
        end else begin
            a = {SFR_BANK, f};
        end
        return a;
    endfunction

    // Two's complement negation with the five affected flags packed in status order.
    function automatic logic [FLAG_W+7:0] negate(input logic [7:0] x);
        logic [7:0] r;
        logic [FLAG_W-1:0] fl;
        r = 8'(~x + 8'h01);
        fl = '0;
        fl[FLAG_N] = r[7];
        fl[FLAG_OV] = (x == 8'h80);
        fl[FLAG_C] = (x == 8'h00);
        fl[FLAG_DC] = (x[3:0] == 4'h0);
        fl[FLAG_Z] = (r == 8'h00);
        return {fl, r};
    endfunction

    // The pin is asynchronous to the core, so it passes two flops; only the second is looked at.
    logic master_clear_pin_meta_reg;
    logic master_clear_pin_sync_reg;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            master_clear_pin_meta_reg <= 1'b1;
            master_clear_pin_sync_reg <= 1'b1;
        end else if (ce_i) begin
            master_clear_pin_meta_reg <= master_clear_pin_n_i;
            master_clear_pin_sync_reg <= master_clear_pin_meta_reg;
        end
    end

    snce_phase_type phase_reg;
    snce_op_type op_reg;
    logic [INSTR_W-1:0] instr_reg;
    logic srst_hit;
    logic clear_all;
    logic stack_push;
    logic stack_pop;
    logic [PC_W-1:0] pc_reg;
    logic [PC_W-1:0] pc_plus2;
    logic [PC_W-1:0] call_disp;
    logic [7:0] operand_reg;
    logic [FLAG_W+7:0] neg_res;

    assign srst_hit = ce_i && phase_reg == PH_Q2 && op_reg == OP_SRST;
    // Software reset, the pin and the core reset all land on the same clear path.
    assign clear_all = sys_rst_i || !master_clear_pin_sync_reg || srst_hit;
    assign stack_push = phase_reg == PH_Q2 && (op_reg == OP_PUSH || op_reg == OP_CALL);
    assign stack_pop = phase_reg == PH_Q3 && op_reg == OP_POP;
    assign pc_plus2 = PC_W'(pc_reg + PC_STEP);
    assign call_disp = {{(PC_W-CALL_OFS_W-1){instr_reg[CALL_OFS_W-1]}}, instr_reg[CALL_OFS_W-1:0], 1'b0};
    assign neg_res = negate(operand_reg);

    always_ff @(posedge sys_clk_i) begin
        if (clear_all) begin
            phase_reg <= PH_Q1;
        end else if (ce_i) begin
            unique case (phase_reg)
                PH_Q1: phase_reg <= PH_Q2;
                PH_Q2: phase_reg <= PH_Q3;
                PH_Q3: phase_reg <= PH_Q4;
                PH_Q4: phase_reg <= PH_Q1;
            endcase
        end
    end

    // Decode at the end of Q1; the flush cycle of a call takes no instruction.
    always_ff @(posedge sys_clk_i) begin
        if (clear_all) begin
            op_reg <= OP_NONE;
            instr_reg <= '0;
            instr_taken_o <= 1'b0;
            foreign_op_o <= 1'b0;
        end else if (ce_i) begin
            instr_taken_o <= 1'b0;
            foreign_op_o <= 1'b0;
            if (phase_reg == PH_Q1) begin
                if (instr_valid_i && !call_flush_o) begin
                    op_reg <= snce_decode(instr_i);
                    instr_reg <= instr_i;
                    instr_taken_o <= 1'b1;
                    foreign_op_o <= snce_decode(instr_i) == OP_OTHER;
                end else begin
                    op_reg <= OP_NONE;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (clear_all) begin
            dmem_addr_o <= '0;
            dmem_rd_o <= 1'b0;
            dmem_wr_o <= 1'b0;
            dmem_wdata_o <= 8'h00;
            operand_reg <= 8'h00;
        end else if (ce_i) begin
            dmem_rd_o <= 1'b0;
            dmem_wr_o <= 1'b0;
            unique case (phase_reg)
                PH_Q1: begin
                    if (instr_valid_i && !call_flush_o && snce_decode(instr_i) == OP_NEG) begin
                        dmem_addr_o <= data_addr(instr_i[ACCESS_BIT], instr_i[7:0], bank_select_o,
                                                 ext_set_en_i, index_base_i);
                        dmem_rd_o <= 1'b1;
                    end
                end
                PH_Q2: begin
                    if (op_reg == OP_NEG) begin
                        operand_reg <= dmem_rdata_i;
                    end
                end
                PH_Q3: begin
                    if (op_reg == OP_NEG) begin
                        dmem_wdata_o <= neg_res[7:0];
                        dmem_wr_o <= 1'b1;
                    end
                end
                PH_Q4: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (clear_all) begin
            status_flags_o <= FLAGS_RESET;
        end else if (ce_i && phase_reg == PH_Q3 && op_reg == OP_NEG) begin
            status_flags_o <= neg_res[FLAG_W+7:8];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (clear_all) begin
            bank_select_o <= BSR_RESET;
        end else if (ce_i && bsr_load_i) begin
            bank_select_o <= bsr_wdata_i & BSR_KEEP_MASK;
        end
    end

    // The PC moves only in Q4, after the Q2 push has already taken the return address.
    always_ff @(posedge sys_clk_i) begin
        if (clear_all) begin
            pc_reg <= PC_RESET;
            call_flush_o <= 1'b0;
        end else if (ce_i && phase_reg == PH_Q4) begin
            call_flush_o <= op_reg == OP_CALL;
            if (op_reg == OP_CALL) begin
                pc_reg <= PC_W'(pc_plus2 + call_disp);
            end else if (op_reg != OP_NONE) begin
                pc_reg <= pc_plus2;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            soft_reset_o <= 1'b0;
        end else if (ce_i) begin
            soft_reset_o <= srst_hit;
        end
    end

    assign pc_o = pc_reg;

    snce_ret_stack #(
        .DEPTH(STACK_DEPTH_P),
        .WIDTH(PC_W)
    ) u_stack (
        .sys_clk_i(sys_clk_i),
        .ce_i(ce_i),
        .clear_i(clear_all),
        .push_i(stack_push),
        .pop_i(stack_pop),
        .push_data_i(pc_plus2),
        .stack_top_o(stack_top_o),
        .level_o(stack_level_o)
    );

endmodule

`default_nettype wire

// File: testbench/snce_core_sva.sv
`timescale 1ns/1ps
`default_nettype none
module snce_core_sva
    import snce_pkg::*;
#(
    parameter int STACK_DEPTH_P = 31
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic [snce_pkg::INSTR_W-1:0] instr_i,
    input wire logic ext_set_en_i,
    input wire logic [snce_pkg::DADDR_W-1:0] index_base_i,
    input wire logic [7:0] dmem_rdata_i,
    input wire logic instr_taken_o,
    input wire logic call_flush_o,
    input wire logic [snce_pkg::DADDR_W-1:0] dmem_addr_o,
    input wire logic dmem_rd_o,
    input wire logic dmem_wr_o,
    input wire logic [7:0] dmem_wdata_o,
    input wire logic [snce_pkg::FLAG_W-1:0] status_flags_o,
    input wire logic [7:0] bank_select_o,
    input wire logic [snce_pkg::PC_W-1:0] pc_o,
    input wire logic [snce_pkg::PC_W-1:0] stack_top_o,
    input wire logic [$clog2(STACK_DEPTH_P+1)-1:0] stack_level_o,
    input wire logic soft_reset_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    logic [INSTR_W-1:0] op_reg;
    logic [PC_W-1:0] tgt_reg;
    // The word decoded in Q2 is the one sampled at the Q1 edge just before.
    always_ff @(posedge sys_clk_i) begin
        op_reg <= instr_i;
    end
    always_ff @(posedge sys_clk_i) begin
        if (instr_taken_o) begin
            tgt_reg <= pc_o + PC_STEP + {{9{op_reg[10]}}, op_reg[10:0], 1'b0};
        end
    end
    sequence s_call;
        instr_taken_o && op_reg[15:11] == 5'b11011;
    endsequence
    sequence s_flush;
        call_flush_o [*4] ##1 !call_flush_o;
    endsequence
    a_neg_result: assert property (dmem_rd_o |-> ##2 dmem_wr_o && dmem_wdata_o == 8'h00 - $past(dmem_rdata_i, 2))
        else $error("negate result wrong");
    a_neg_flags: assert property (dmem_wr_o |-> status_flags_o[FLAG_Z] == (dmem_wdata_o == 8'h00)
        && status_flags_o[FLAG_N] == dmem_wdata_o[7]) else $error("negate flags wrong");
    a_addr_banked: assert property (dmem_rd_o && op_reg[ACCESS_BIT]
        |-> dmem_addr_o == {$past(bank_select_o[3:0]), op_reg[7:0]}) else $error("banked address wrong");
    a_addr_access: assert property (dmem_rd_o && !op_reg[ACCESS_BIT] && !(ext_set_en_i && op_reg[7:0] <= IDX_LIMIT)
        |-> dmem_addr_o == {((op_reg[7:0] < (ext_set_en_i ? ACCESS_SPLIT_EXT : ACCESS_SPLIT_STD)) ? LOW_BANK : SFR_BANK),
        op_reg[7:0]}) else $error("access bank address wrong");
    a_addr_indexed: assert property (dmem_rd_o && !op_reg[ACCESS_BIT] && ext_set_en_i && op_reg[7:0] <= IDX_LIMIT
        |-> dmem_addr_o == index_base_i + {4'h0, op_reg[7:0]}) else $error("indexed address wrong");
    a_push_top: assert property (instr_taken_o && op_reg == OPC_PUSH |=> stack_top_o == pc_o + PC_STEP)
        else $error("push value wrong");
    a_pop_level: assert property (instr_taken_o && op_reg == OPC_POP && stack_level_o != 0
        |-> ##2 stack_level_o == $past(stack_level_o, 2) - 1'b1) else $error("pop level wrong");
    a_call_flush: assert property (s_call |-> ##3 s_flush)
        else $error("call flush length wrong");
    a_call_order: assert property (s_call |=> stack_top_o == pc_o + PC_STEP ##2 pc_o == tgt_reg)
        else $error("call push or target wrong");
    a_soft_clear: assert property (instr_taken_o && op_reg == OPC_SRST |=> soft_reset_o && pc_o == PC_RESET
        && stack_level_o == 0 && status_flags_o == FLAGS_RESET) else $error("software reset incomplete");
    a_idle_quiet: assert property (instr_taken_o && (op_reg == OPC_IDLE_ZERO || op_reg[15:12] == 4'hF)
        |=> ($stable(status_flags_o) && $stable(stack_level_o)) [*3]) else $error("idle changed state");
    a_bank_upper: assert property (bank_select_o[7:4] == 4'h0)
        else $error("bank upper bits set");
endmodule
`default_nettype wire

// File: testbench/snce_dmem_model.sv
`timescale 1ns/1ps
`default_nettype none
module snce_dmem_model (
    input wire logic sys_clk_i,
    input wire logic [11:0] addr_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [0:4095];
    logic [7:0] last_reg = 8'h00;
    // Outside a read the bus shows the inverse of the last byte, so stale data never passes for fresh.
    assign rdata_o = rd_i ? mem[addr_i] : ~last_reg;
    always @(posedge sys_clk_i) begin
        if (rd_i) begin
            last_reg <= mem[addr_i];
        end
        if (wr_i) begin
            mem[addr_i] <= wdata_i;
        end
    end
endmodule
`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import snce_pkg::*;
    localparam int STACK_DEPTH_P = 31;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [15:0] instr_i = 16'h0000;
    logic instr_valid_i = 1'b0;
    logic ext_set_en_i = 1'b0;
    logic bsr_load_i = 1'b0;
    logic [7:0] bsr_wdata_i = 8'h00;
    logic [11:0] index_base_i = 12'h300;
    logic master_clear_pin_n = 1'b1;
    logic [7:0] rdata;
    logic taken, foreign, flush, rd, wr, srst;
    logic [11:0] addr;
    logic [7:0] wdata, bank;
    logic [4:0] flags, level;
    logic [20:0] pc, top;
    int num_errors = 0;
    int n_checks = 0;
    // The software reset strobe stands for one cycle only, so it is caught here and looked at later.
    logic srst_seen = 1'b0;
    always #2 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        if (srst === 1'b1) begin
            srst_seen <= 1'b1;
        end
    end
    snce_core #(.STACK_DEPTH_P(STACK_DEPTH_P)) dut_u (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1),
        .instr_i(instr_i), .instr_valid_i(instr_valid_i), .ext_set_en_i(ext_set_en_i), .bsr_load_i(bsr_load_i),
        .bsr_wdata_i(bsr_wdata_i), .index_base_i(index_base_i), .master_clear_pin_n_i(master_clear_pin_n),
        .dmem_rdata_i(rdata), .instr_taken_o(taken), .foreign_op_o(foreign), .call_flush_o(flush),
        .dmem_addr_o(addr), .dmem_rd_o(rd), .dmem_wr_o(wr), .dmem_wdata_o(wdata), .status_flags_o(flags),
        .bank_select_o(bank), .pc_o(pc), .stack_top_o(top), .stack_level_o(level), .soft_reset_o(srst));
    snce_dmem_model dm_u (.sys_clk_i(sys_clk_i), .addr_i(addr), .rd_i(rd), .wr_i(wr), .wdata_i(wdata),
        .rdata_o(rdata));
    task automatic end_of_test;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    // Holds the word valid until it is taken, so a slot refused by a call flush is simply retried.
    task automatic issue(input logic [15:0] w);
        int i;
        instr_i = w;
        instr_valid_i = 1'b1;
        for (i = 0; i < 12 && taken !== 1'b1; i++) begin
            @(negedge sys_clk_i);
        end
        if (i == 12) begin
            num_errors++;
            end_of_test();
        end
        instr_valid_i = 1'b0;
        repeat (3) @(negedge sys_clk_i);
    endtask
    task automatic neg(input logic [15:0] w, input logic ext, input logic [11:0] a, input logic [7:0] v,
                       input logic [4:0] fl);
        ext_set_en_i = ext;
        dm_u.mem[a] = v;
        issue(w);
        chk(32'(dm_u.mem[a]), 32'(8'(~v + 8'h01)));
        chk(32'(flags), 32'(fl));
    endtask
    task automatic stk(input logic [15:0] w, input logic [20:0] t, input logic [4:0] l, input logic [20:0] p);
        issue(w);
        chk(32'(top), 32'(t));
        chk(32'(level), 32'(l));
        chk(32'(pc), 32'(p));
    endtask
    initial begin
        repeat (8) @(negedge sys_clk_i);
        sys_rst_i = 1'b0;
        chk(32'({pc, level, flags, bank}), 32'h0);
        bsr_load_i = 1'b1;
        bsr_wdata_i = 8'hA5;
        @(negedge sys_clk_i);
        bsr_load_i = 1'b0;
        @(negedge sys_clk_i);
        chk(32'(bank), 32'h05);
        neg(16'h6D3A, 1'b0, 12'h53A, 8'h3A, 5'h10);
        neg(16'h6C90, 1'b0, 12'hF90, 8'h00, 5'h07);
        neg(16'h6C10, 1'b0, 12'h010, 8'h80, 5'h1A);
        neg(16'h6C20, 1'b1, 12'h320, 8'h01, 5'h10);
        neg(16'h6C70, 1'b1, 12'hF70, 8'hFF, 5'h00);
        stk(16'h0005, 21'h00C, 5'h01, 21'h00C);
        stk(16'h0005, 21'h00E, 5'h02, 21'h00E);
        stk(16'h0006, 21'h00C, 5'h01, 21'h010);
        stk(16'hDBFF, 21'h012, 5'h02, 21'h810);
        stk(16'h0005, 21'h812, 5'h03, 21'h812);
        stk(16'h0006, 21'h012, 5'h02, 21'h814);
        stk(16'hDC00, 21'h816, 5'h03, 21'h016);
        stk(16'h0000, 21'h816, 5'h03, 21'h018);
        stk(16'hF123, 21'h816, 5'h03, 21'h01A);
        chk(32'(flags), 32'h0);
        chk(32'(srst_seen), 32'h0);
        stk(16'h00FF, 21'h0, 5'h00, 21'h0);
        chk(32'({srst_seen, flags, bank}), 32'h2000);
        issue(16'h0000);
        master_clear_pin_n = 1'b0;
        repeat (6) @(negedge sys_clk_i);
        chk(32'(pc), 32'h0);
        master_clear_pin_n = 1'b1;
        end_of_test();
    end
endmodule
bind snce_core snce_core_sva #(.STACK_DEPTH_P(STACK_DEPTH_P)) chk_u (.*);
`default_nettype wire
